/* flash_cmd_pkg.sv */
/*
 * Shared constants for the serial flash identification, parameter-table
 * and suspend/resume command logic and for its host-side controller.
 * Assumes both ends run on one 200 MHz clock with the link clock sampled.
 */
package flash_cmd_pkg;
	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;	// Two dummies, one address byte
	localparam logic [7:0] OP_THREE_BYTE_ID   = 8'h9F;	// Maker, type, capacity
	localparam logic [7:0] OP_UNIQUE_NUMBER   = 8'h4B;	// Four dummies then 128 bits
	localparam logic [7:0] OP_PARAM_TABLE     = 8'h5A;	// Three address bytes, one dummy
	localparam logic [7:0] OP_SUSPEND         = 8'h75;
	localparam logic [7:0] OP_RESUME          = 8'h7A;
	localparam logic [7:0] OP_STATUS_WRITE_1  = 8'h01;
	localparam logic [7:0] OP_STATUS_WRITE_2  = 8'h31;
	localparam logic [7:0] OP_STATUS_WRITE_3  = 8'h11;
	localparam logic [7:0] OP_SEC_ERASE       = 8'h44;
	localparam logic [7:0] OP_SEC_PROGRAM     = 8'h42;
	localparam logic [7:0] OP_ERASE_4K        = 8'h20;
	localparam logic [7:0] OP_ERASE_32K       = 8'h52;
	localparam logic [7:0] OP_ERASE_64K       = 8'hD8;
	localparam logic [7:0] OP_ERASE_CHIP_1    = 8'hC7;
	localparam logic [7:0] OP_ERASE_CHIP_2    = 8'h60;
	localparam logic [7:0] OP_PAGE_PROGRAM_1  = 8'h02;
	localparam logic [7:0] OP_PAGE_PROGRAM_2  = 8'h32;

	// ------------------------------------------------------------
	// Header bytes of the parameter table
	// ------------------------------------------------------------
	localparam logic [31:0] PT_SIGNATURE   = 32'h5044_4653;	// Sent low byte first
	localparam logic [7:0]  PT_MINOR_REV   = 8'h00;
	localparam logic [7:0]  PT_MAJOR_REV   = 8'h01;
	localparam logic [7:0]  PT_HEADER_CNT  = 8'h01;
	localparam logic [7:0]  PT_FILL        = 8'hFF;
	localparam logic [7:0]  PT_HDR0_ID     = 8'h00;
	localparam logic [7:0]  PT_HDR0_LEN    = 8'h09;
	localparam logic [23:0] PT_HDR0_PTR    = 24'h00_0030;
	localparam logic [7:0]  PT_HDR1_LEN    = 8'h03;
	localparam logic [23:0] PT_HDR1_PTR    = 24'h00_0060;
	localparam logic [7:0]  PT_ADDR_MASK   = 8'hFF;		// Table wraps at this address

	// ------------------------------------------------------------
	// Byte counts and timing
	// ------------------------------------------------------------
	localparam int MDID_DUMMY_BYTES  = 2;
	localparam int UNIQUE_DUMMY_BYTES = 4;
	localparam int PT_ADDR_BYTES     = 3;
	localparam int CLK_PERIOD_PS     = 5000;	// 200 MHz
	localparam int RESUME_TIME_NS    = 200;	// Longest time to raise in-progress
	localparam int RESUME_CYCLES     = (RESUME_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int SUSPEND_TIME_NS   = 100;	// Assumed suspend latency limit
	localparam int SUSPEND_CYCLES    = (SUSPEND_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int LINK_HALF_CYCLES  = 8;	// Host divider: 80 ns link clock
endpackage

/* flash_link_if.sv */
/*
 * Serial link between the flash command logic and the host controller.
 * Assumes both ends share clk_in; the testbench instantiates and joins them.
 */
`timescale 1ns/100ps
interface flash_link_if;
	logic select_n;	// Chip select, active low, from host
	logic sclk;	// Serial clock from host
	logic si;	// Serial data to device
	logic so;	// Serial data to host

	modport device (input select_n, input sclk, input si, output so);
	modport host   (output select_n, output sclk, output si, input so);
endinterface

/* flash_cmd_device.sv */
/*
 * Device end: decodes identification, unique-number, parameter-table and
 * suspend/resume commands from the serial link and shifts answers out.
 * Assumes select, clock and data arrive asynchronously and are synchronised
 * here; program/erase progress is reported by the array controller.
 */
`timescale 1ns/100ps
// Function
// - 90h, two dummies, address, then IDs
// - Address 00h maker first, 01h device first
// - ID pair repeats while select low
// - Bits leave on falling edge, MSB first
// - 9Fh returns maker, type, capacity
// - 9Fh ignored during program or erase
// - Raising select ends output, back to standby
// - Host avoids 9Fh in deep power-down
// - Suspend accepted only when busy, unsuspended
// - Suspend flag set now, busy cleared later
// - Program suspend refuses writes, erases, programs
// - Erase suspend refuses writes, erases; program allowed
// - Reset clears suspended state
// - Resume accepted only suspended and idle
// - Resume clears suspend, busy within 200 ns
// - 4Bh, four dummies, 128-bit number
// - 5Ah, three address bytes, one dummy
// - Table address increments and wraps
// - Table read refused during busy cycle
// - Signature and revision header bytes
// - First header: 9 dwords at 30h
// - Second header: maker, 3 dwords at 60h
module flash_cmd_device #(
	parameter logic [7:0]   MAKER_ID    = 8'hA5,	// Arbitrary value
	parameter logic [7:0]   DEVICE_ID   = 8'h17,	// Arbitrary value
	parameter logic [7:0]   MEM_TYPE    = 8'h40,	// Arbitrary value
	parameter logic [7:0]   CAPACITY    = 8'h18,	// Arbitrary value
	parameter logic [127:0] UNIQUE_NUM  = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978	// Arbitrary
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	flash_link_if.device    link,
	input  wire logic       program_running_in,	// Page program under way
	input  wire logic       erase_running_in,	// Sector/block erase under way
	input  wire logic       write_running_in,	// Status write under way
	output logic            op_in_progress_flag_out,
	output logic [1:0]      suspended_flags_out,	// [0] program, [1] erase
	output logic            suspend_req_out,	// Pulse: halt array operation
	output logic            resume_req_out,	// Pulse: continue array operation
	output logic            cmd_refused_out	// Pulse: opcode refused in suspend
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_OPCODE = 5'b00001,	// Collecting opcode
		ST_ARG    = 5'b00010,	// Collecting dummies and address
		ST_SEND   = 5'b00100,	// Shifting answer bytes
		ST_IGNORE = 5'b01000,	// Rest of frame ignored
		ST_DONE   = 5'b10000	// Opcode-only command handled
	} phase_t;

	typedef struct packed {
		logic [1:0]  cs_sync;	// Select synchroniser
		logic [2:0]  ck_sync;	// Clock synchroniser plus last value
		logic [1:0]  di_sync;	// Data synchroniser
		phase_t      phase;
		logic [7:0]  opcode;
		logic [7:0]  shreg;	// Incoming byte
		logic [2:0]  bitcnt;
		logic [2:0]  argcnt;	// Argument bytes still due
		logic [7:0]  addr;	// Order select or table address
		logic [4:0]  bytecnt;	// Answer byte index
		logic [7:0]  outbyte;	// Byte being shifted out
		logic        so;
		logic        busy;	// In-progress flag
		logic [1:0]  susp;
		logic [5:0]  timer;	// Suspend/resume latency
		logic        susp_pend;
		logic        resume_pend;
		logic        susp_req;
		logic        resume_req;
		logic        refused;
	} dev_state_t;

	dev_state_t st;
	dev_state_t next_st;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Parameter table lookup; unnamed addresses give the fill byte
	function automatic logic [7:0] table_byte(input logic [7:0] a);
		case (a)
			8'h00: table_byte = PT_SIG(0);
			8'h01: table_byte = PT_SIG(1);
			8'h02: table_byte = PT_SIG(2);
			8'h03: table_byte = PT_SIG(3);
			8'h04: table_byte = flash_cmd_pkg::PT_MINOR_REV;
			8'h05: table_byte = flash_cmd_pkg::PT_MAJOR_REV;
			8'h06: table_byte = flash_cmd_pkg::PT_HEADER_CNT;
			8'h08: table_byte = flash_cmd_pkg::PT_HDR0_ID;
			8'h09: table_byte = flash_cmd_pkg::PT_MINOR_REV;
			8'h0A: table_byte = flash_cmd_pkg::PT_MAJOR_REV;
			8'h0B: table_byte = flash_cmd_pkg::PT_HDR0_LEN;
			8'h0C: table_byte = flash_cmd_pkg::PT_HDR0_PTR[7:0];
			8'h0D: table_byte = flash_cmd_pkg::PT_HDR0_PTR[15:8];
			8'h0E: table_byte = flash_cmd_pkg::PT_HDR0_PTR[23:16];
			8'h10: table_byte = MAKER_ID;
			8'h11: table_byte = flash_cmd_pkg::PT_MINOR_REV;
			8'h12: table_byte = flash_cmd_pkg::PT_MAJOR_REV;
			8'h13: table_byte = flash_cmd_pkg::PT_HDR1_LEN;
			8'h14: table_byte = flash_cmd_pkg::PT_HDR1_PTR[7:0];
			8'h15: table_byte = flash_cmd_pkg::PT_HDR1_PTR[15:8];
			8'h16: table_byte = flash_cmd_pkg::PT_HDR1_PTR[23:16];
			default: table_byte = flash_cmd_pkg::PT_FILL;
		endcase
	endfunction

	// Signature byte n, low byte first
	function automatic logic [7:0] PT_SIG(input int n);
		PT_SIG = flash_cmd_pkg::PT_SIGNATURE[8*n +: 8];
	endfunction

	// Byte to send for a given command and answer index
	function automatic logic [7:0] answer_byte(input logic [7:0] op, input logic [7:0] a,
			input logic [4:0] idx);
		answer_byte = flash_cmd_pkg::PT_FILL;
		case (op)
			flash_cmd_pkg::OP_MAKER_DEVICE_ID: begin
				// Alternate forever; address bit 0 swaps the order
				answer_byte = (idx[0] ^ a[0]) ? DEVICE_ID : MAKER_ID;
			end
			flash_cmd_pkg::OP_THREE_BYTE_ID: begin
				case (idx)
					5'd0:    answer_byte = MAKER_ID;
					5'd1:    answer_byte = MEM_TYPE;
					5'd2:    answer_byte = CAPACITY;
					default: answer_byte = flash_cmd_pkg::PT_FILL;
				endcase
			end
			flash_cmd_pkg::OP_UNIQUE_NUMBER: begin
				// MSB byte first; past 16 bytes it repeats
				answer_byte = UNIQUE_NUM[8*(15 - int'(idx[3:0])) +: 8];
			end
			flash_cmd_pkg::OP_PARAM_TABLE: answer_byte = table_byte(a);
			default: answer_byte = flash_cmd_pkg::PT_FILL;
		endcase
	endfunction

	// Opcodes that a suspended program or erase must not see
	function automatic logic refused_in_suspend(input logic [7:0] op, input logic [1:0] s);
		logic common;
		common = (op == flash_cmd_pkg::OP_STATUS_WRITE_1) || (op == flash_cmd_pkg::OP_STATUS_WRITE_2)
			|| (op == flash_cmd_pkg::OP_STATUS_WRITE_3) || (op == flash_cmd_pkg::OP_SEC_ERASE)
			|| (op == flash_cmd_pkg::OP_ERASE_4K) || (op == flash_cmd_pkg::OP_ERASE_32K)
			|| (op == flash_cmd_pkg::OP_ERASE_64K) || (op == flash_cmd_pkg::OP_ERASE_CHIP_1)
			|| (op == flash_cmd_pkg::OP_ERASE_CHIP_2);
		refused_in_suspend = (s[1] && common)
			|| (s[0] && (common || (op == flash_cmd_pkg::OP_SEC_PROGRAM)
			|| (op == flash_cmd_pkg::OP_PAGE_PROGRAM_1)
			|| (op == flash_cmd_pkg::OP_PAGE_PROGRAM_2)));
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic       cs_low;	// Synchronised select
	logic       rise;	// Link clock rising edge
	logic       fall;	// Link clock falling edge
	logic [7:0] byte_in;	// Byte completed by this rising edge
	logic       array_busy;	// Array reports any long cycle

	always_comb begin
		next_st = st;
		next_st.cs_sync = {st.cs_sync[0], ~link.select_n};
		next_st.ck_sync = {st.ck_sync[1:0], link.sclk};
		next_st.di_sync = {st.di_sync[0], link.si};
		next_st.susp_req = 1'b0;
		next_st.resume_req = 1'b0;
		next_st.refused = 1'b0;
		cs_low = st.cs_sync[1];
		rise = st.ck_sync[1] & ~st.ck_sync[2];
		fall = ~st.ck_sync[1] & st.ck_sync[2];
		byte_in = {st.shreg[6:0], st.di_sync[1]};
		array_busy = program_running_in | erase_running_in | write_running_in;

		// Delayed flag moves after accepted suspend or resume
		if (st.timer != '0) begin
			next_st.timer = st.timer - 6'd1;
		end else if (st.susp_pend) begin
			next_st.busy = 1'b0;
			next_st.susp_pend = 1'b0;
		end else if (st.resume_pend) begin
			next_st.busy = 1'b1;
			next_st.resume_pend = 1'b0;
		end else if (st.susp == 2'b00) begin
			next_st.busy = program_running_in | erase_running_in;
		end

		if (!cs_low) begin
			// Deselect ends any command and returns to standby
			next_st.phase = ST_OPCODE;
			next_st.bitcnt = '0;
			next_st.so = 1'b0;
		end else begin
			case (st.phase)
				ST_OPCODE: begin
					if (rise) begin
						next_st.shreg = byte_in;
						next_st.bitcnt = st.bitcnt + 3'd1;
						if (st.bitcnt == 3'd7) begin
							next_st.opcode = byte_in;
							next_st.phase = ST_IGNORE;
							next_st.bytecnt = '0;
							case (byte_in)
								flash_cmd_pkg::OP_MAKER_DEVICE_ID: begin
									next_st.argcnt = 3'(flash_cmd_pkg::MDID_DUMMY_BYTES + 1);
									next_st.phase = ST_ARG;
								end
								flash_cmd_pkg::OP_THREE_BYTE_ID: begin
									// Not decoded while the array is busy
									if (!array_busy) next_st.phase = ST_SEND;
								end
								flash_cmd_pkg::OP_UNIQUE_NUMBER: begin
									next_st.argcnt = 3'(flash_cmd_pkg::UNIQUE_DUMMY_BYTES);
									next_st.phase = ST_ARG;
								end
								flash_cmd_pkg::OP_PARAM_TABLE: begin
									next_st.argcnt = 3'(flash_cmd_pkg::PT_ADDR_BYTES + 1);
									if (!array_busy) next_st.phase = ST_ARG;
								end
								flash_cmd_pkg::OP_SUSPEND: begin
									next_st.phase = ST_DONE;
									if (st.busy && st.susp == 2'b00 && !write_running_in) begin
										next_st.susp = {erase_running_in, program_running_in};
										next_st.susp_pend = 1'b1;
										next_st.timer = 6'(flash_cmd_pkg::SUSPEND_CYCLES - 1);
										next_st.susp_req = 1'b1;
									end
								end
								flash_cmd_pkg::OP_RESUME: begin
									next_st.phase = ST_DONE;
									if (st.susp != 2'b00 && !st.busy && !st.susp_pend) begin
										next_st.susp = 2'b00;
										next_st.resume_pend = 1'b1;
										next_st.timer = 6'(flash_cmd_pkg::RESUME_CYCLES - 1);
										next_st.resume_req = 1'b1;
									end
								end
								default: begin
									next_st.refused = refused_in_suspend(byte_in, st.susp);
								end
							endcase
						end
					end
				end
				ST_ARG: begin
					if (rise) begin
						next_st.shreg = byte_in;
						next_st.bitcnt = st.bitcnt + 3'd1;
						if (st.bitcnt == 3'd7) begin
							next_st.argcnt = st.argcnt - 3'd1;
							// Low address byte sits last for 90h, before the dummy for 5Ah
							if ((st.opcode == flash_cmd_pkg::OP_MAKER_DEVICE_ID && st.argcnt == 3'd1)
								|| (st.opcode == flash_cmd_pkg::OP_PARAM_TABLE
								&& st.argcnt == 3'd2)) begin
								next_st.addr = byte_in;
							end
							if (st.argcnt == 3'd1) next_st.phase = ST_SEND;
						end
					end
				end
				ST_SEND: begin
					if (fall) begin
						// Load at byte start, shift MSB first
						if (st.bitcnt == 3'd0) begin
							next_st.outbyte = answer_byte(st.opcode, st.addr, st.bytecnt);
							next_st.so = next_st.outbyte[7];
						end else begin
							next_st.so = st.outbyte[3'd7 - st.bitcnt];
						end
						next_st.bitcnt = st.bitcnt + 3'd1;
						if (st.bitcnt == 3'd7) begin
							next_st.bytecnt = st.bytecnt + 5'd1;
							if (st.opcode == flash_cmd_pkg::OP_PARAM_TABLE) begin
								next_st.addr = (st.addr + 8'd1) & flash_cmd_pkg::PT_ADDR_MASK;
							end
						end
					end
				end
				ST_IGNORE, ST_DONE: next_st.phase = st.phase;
				default: next_st.phase = ST_OPCODE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers; reset also drops any suspension
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st <= '{phase: ST_OPCODE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign link.so = st.so;
	assign op_in_progress_flag_out = st.busy;
	assign suspended_flags_out = st.susp;
	assign suspend_req_out = st.susp_req;
	assign resume_req_out = st.resume_req;
	assign cmd_refused_out = st.refused;
endmodule

/* flash_cmd_host.sv */
/*
 * Host end: frames one command on the serial link, makes the link clock
 * by dividing clk_in, and hands answer bytes out through a two-entry buffer.
 * Assumes the user keeps the request stable until it is taken.
 */
`timescale 1ns/100ps
module flash_cmd_host (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	flash_link_if.host      link,
	input  wire logic       req_valid_in,	// Start a command
	input  wire logic [7:0] req_opcode_in,
	input  wire logic [31:0] req_args_in,	// Argument bytes, MSB byte first
	input  wire logic [2:0] req_arg_cnt_in,	// Dummy and address bytes
	input  wire logic [4:0] req_rd_cnt_in,	// Answer bytes wanted
	output logic            req_ready_out,	// Idle, request taken
	output logic            rd_valid_out,
	output logic [7:0]      rd_data_out,
	input  wire logic       rd_ready_in
);
	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_SHIFT = 4'b0010,	// Opcode and arguments out
		H_READ  = 4'b0100,	// Answer bytes in
		H_END   = 4'b1000	// Select high
	} hphase_t;

	typedef struct packed {
		hphase_t     phase;
		logic [3:0]  div;	// Link clock divider
		logic        sclk;
		logic        sel_n;
		logic        si;
		logic [39:0] tx;	// Outgoing bits
		logic [5:0]  txbits;
		logic [4:0]  rdleft;
		logic [2:0]  bitcnt;
		logic [7:0]  rx;
		logic [1:0]  so_sync;	// Data synchroniser
		logic [7:0]  buf0;	// Two-entry buffer
		logic [7:0]  buf1;
		logic [1:0]  count;
		logic        valid;	// Buffer holds a byte; registered copy of count != 0
		logic        ready;
	} host_state_t;

	host_state_t st;
	host_state_t next_st;
	logic tick;	// Divider enable pulse
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// Link framing; reading stalls while the buffer is full
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.so_sync = {st.so_sync[0], link.so};
		tick = (st.div == 4'(flash_cmd_pkg::LINK_HALF_CYCLES - 1));
		push = 1'b0;
		pop = rd_ready_in && (st.count != 2'd0);
		next_st.div = tick ? 4'd0 : st.div + 4'd1;
		next_st.ready = 1'b0;
		case (st.phase)
			H_IDLE: begin
				next_st.div = '0;
				if (req_valid_in) begin
					next_st.phase = H_SHIFT;
					next_st.sel_n = 1'b0;
					next_st.tx = {req_opcode_in, req_args_in};
					next_st.txbits = 6'(8 + 8 * int'(req_arg_cnt_in));
					next_st.rdleft = req_rd_cnt_in;
					next_st.bitcnt = '0;
					next_st.si = req_opcode_in[7];
					next_st.ready = 1'b1;
				end
			end
			H_SHIFT: if (tick) begin
				next_st.sclk = ~st.sclk;
				if (st.sclk) begin	// Falling edge: next bit
					next_st.tx = {st.tx[38:0], 1'b0};
					next_st.si = st.tx[38];
					// Leave only after the falling edge that follows the last rising edge
					if (st.txbits == 6'd0) next_st.phase = (st.rdleft == 0) ? H_END : H_READ;
				end else begin
					next_st.txbits = st.txbits - 6'd1;
				end
			end
			H_READ: if (tick && !(st.count == 2'd2 && !st.sclk)) begin
				next_st.sclk = ~st.sclk;
				if (!st.sclk) begin	// Rising edge: sample
					next_st.rx = {st.rx[6:0], st.so_sync[1]};
					next_st.bitcnt = st.bitcnt + 3'd1;
					if (st.bitcnt == 3'd7) begin
						push = 1'b1;
						next_st.rdleft = st.rdleft - 5'd1;
						if (st.rdleft == 5'd1) next_st.phase = H_END;
					end
				end
			end
			H_END: if (tick) begin
				if (st.sclk) next_st.sclk = 1'b0;
				else begin
					next_st.sel_n = 1'b1;
					next_st.phase = H_IDLE;
				end
			end
			default: next_st.phase = H_IDLE;
		endcase
		// Buffer: entry 0 is the head
		if (pop) begin
			next_st.buf0 = st.buf1;
			next_st.count = st.count - 2'd1;
		end
		if (push) begin
			if ((pop ? st.count - 2'd1 : st.count) == 2'd0) next_st.buf0 = {st.rx[6:0], st.so_sync[1]};
			else next_st.buf1 = {st.rx[6:0], st.so_sync[1]};
			next_st.count = (pop ? st.count : st.count + 2'd1);
		end
		// Output flag comes straight from a flip-flop
		next_st.valid = (next_st.count != 2'd0);
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st <= '{phase: H_IDLE, sel_n: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign link.select_n = st.sel_n;
	assign link.sclk = st.sclk;
	assign link.si = st.si;
	assign req_ready_out = st.ready;
	assign rd_valid_out = st.valid;
	assign rd_data_out = st.buf0;
endmodule

/* flash_cmd_props.sv */
/* Checker for the flash link and device status outputs.
   Assumes one clock domain; placed beside the link interface. */
`timescale 1ns/100ps
module flash_cmd_props (
	input wire logic       clk_in,
	input wire logic       nrst_in,
	input wire logic       select_n,
	input wire logic       sclk,
	input wire logic       si,
	input wire logic       so,
	input wire logic       op_in_progress_flag_out,
	input wire logic [1:0] suspended_flags_out,
	input wire logic       suspend_req_out,
	input wire logic       resume_req_out,
	input wire logic       cmd_refused_out
);
	localparam int SUS_MAX = 24;	// Suspend latency plus sync slack
	localparam int RES_MAX = 41;	// 200 ns plus one register stage
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	AST_SO_FALL: assert property ($changed(so) |-> !sclk)
		else $error("so moved while link clock high");
	AST_SI_RISE: assert property ($rose(sclk) |-> $stable(si))
		else $error("si moved at link clock rise");
	AST_SUS_OK: assert property (suspend_req_out |->
		$past(op_in_progress_flag_out) && $past(suspended_flags_out) == 2'b00)
		else $error("suspend taken when not allowed");
	AST_SUS_FLAG: assert property (suspend_req_out |-> suspended_flags_out != 2'b00)
		else $error("suspend flag not set");
	AST_SUS_IDLE: assert property (suspend_req_out |-> ##[1:SUS_MAX] !op_in_progress_flag_out)
		else $error("busy not cleared after suspend");
	AST_RES_OK: assert property (resume_req_out |->
		$past(suspended_flags_out) != 2'b00 && !$past(op_in_progress_flag_out))
		else $error("resume taken when not allowed");
	AST_RES_FLAG: assert property (resume_req_out |-> suspended_flags_out == 2'b00)
		else $error("suspend flag kept after resume");
	AST_RES_BUSY: assert property (resume_req_out |-> ##[1:RES_MAX] op_in_progress_flag_out)
		else $error("busy late after resume");
	AST_ONE_FLAG: assert property (suspended_flags_out != 2'b11)
		else $error("both suspend flags set");
	AST_REF_SUS: assert property (cmd_refused_out |-> suspended_flags_out != 2'b00)
		else $error("refusal outside suspend");
	AST_RST: assert property (disable iff (1'b0) !nrst_in |=> suspended_flags_out == 2'b00)
		else $error("reset kept suspend state");
	COV_SUS: cover property (suspend_req_out);
	COV_RES: cover property (resume_req_out);
	COV_REF: cover property (cmd_refused_out);
endmodule

/* flash_id_sfdp_suspend_cmds_bench.sv */
/* Bench joining device and host ends over the link interface.
   Assumes one 200 MHz clock; host makes the link clock. */
`timescale 1ns/100ps
module flash_id_sfdp_suspend_cmds_bench;
	localparam logic [7:0]   MK = 8'h5C;	// Arbitrary
	localparam logic [7:0]   DV = 8'h2E;	// Arbitrary
	localparam logic [7:0]   MT = 8'h61;	// Arbitrary
	localparam logic [7:0]   CP = 8'h19;	// Arbitrary
	localparam logic [127:0] UN = 128'h1111_2222_3333_4444_5555_6666_7777_8888; // Arbitrary
	localparam logic [7:0] PNO [12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20,
		8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
	logic clk_in = 0, nrst_in = 0, prog = 0, ers = 0, wr = 0;
	logic req_valid_in = 0, rd_ready_in = 1, req_ready_out, rd_valid_out;
	logic [7:0] req_opcode_in = 0, rd_data_out;
	logic [31:0] req_args_in = 0;
	logic [2:0] req_arg_cnt_in = 0;
	logic [4:0] req_rd_cnt_in = 0;
	logic op_in_progress_flag_out, suspend_req_out, resume_req_out, cmd_refused_out;
	logic [1:0] suspended_flags_out;
	int n_mismatch = 0, samples_checked = 0, n_ref = 0, cyc = 0;
	logic [7:0] got[$];	// Answer bytes of the last command

	flash_link_if lk ();
	flash_cmd_device #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP),
		.UNIQUE_NUM(UN)) u_flash_cmd_device (.clk_in, .nrst_in, .link(lk),
		.program_running_in(prog), .erase_running_in(ers), .write_running_in(wr),
		.op_in_progress_flag_out, .suspended_flags_out, .suspend_req_out,
		.resume_req_out, .cmd_refused_out);
	flash_cmd_host u_flash_cmd_host (.clk_in, .nrst_in, .link(lk), .req_valid_in,
		.req_opcode_in, .req_args_in, .req_arg_cnt_in, .req_rd_cnt_in, .req_ready_out,
		.rd_valid_out, .rd_data_out, .rd_ready_in);
	flash_cmd_props u_flash_cmd_props (.clk_in, .nrst_in, .select_n(lk.select_n),
		.sclk(lk.sclk), .si(lk.si), .so(lk.so), .op_in_progress_flag_out,
		.suspended_flags_out, .suspend_req_out, .resume_req_out, .cmd_refused_out);

	initial forever #2.5 clk_in = ~clk_in;
	// Refusal pulse count and hang limit
	always @(posedge clk_in) begin
		cyc++;
		if (cmd_refused_out === 1'b1) n_ref++;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Bytes s..s+k-1 of the answer, first byte highest
	function automatic logic [127:0] pk(int s, int k);
		logic [127:0] r;
		r = '0;
		for (int i = s; i < s + k; i++) r = {r[119:0], got[i]};
		return r;
	endfunction

	// One framed command; stall holds rd_ready low to back up the buffer
	task automatic issue(logic [7:0] op, logic [31:0] a, logic [2:0] ac, logic [4:0] rc,
		int stall);
		int n;
		got.delete();
		@(posedge clk_in);
		req_valid_in <= 1;
		req_opcode_in <= op;
		req_args_in <= a;
		req_arg_cnt_in <= ac;
		req_rd_cnt_in <= rc;
		for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(posedge clk_in);
		req_valid_in <= 0;
		if (stall > 0) begin
			rd_ready_in <= 0;
			repeat (stall) @(posedge clk_in);
			rd_ready_in <= 1;
		end
		for (n = 0; n < 20000 && got.size() < rc; n++) begin
			@(negedge clk_in);
			if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) got.push_back(rd_data_out);
			@(posedge clk_in);
		end
		for (n = 0; n < 3000 && lk.select_n !== 1'b1; n++) @(posedge clk_in);
		repeat (8) @(posedge clk_in);
	endtask

	task automatic t_ident();
		// Host never sends 9Fh in deep power-down; this block has no such state
		issue(8'h9F, 0, 0, 1, 0);
		check("ident_cut", pk(0, 1), MK);
		issue(8'h9F, 0, 0, 3, 0);
		check("ident", pk(0, 3), {MK, MT, CP});
		issue(8'h90, 32'h0000_0000, 3, 4, 0);
		check("mdid_0", pk(0, 4), {MK, DV, MK, DV});
		issue(8'h90, 32'h0000_0100, 3, 5, 0);
		check("mdid_1", pk(0, 5), {DV, MK, DV, MK, DV});
	endtask

	task automatic t_tables();
		issue(8'h4B, 0, 4, 16, 600);
		check("unique", pk(0, 16), UN);
		issue(8'h5A, 0, 4, 24, 0);
		check("tbl_lo", pk(0, 16), 128'h5346_4450_0001_01FF_0000_0109_3000_00FF);
		check("tbl_hi", pk(16, 8), {64'h0, MK, 56'h0001_0360_0000_FF});
		issue(8'h5A, 32'h0000_FE00, 4, 4, 0);
		check("tbl_wrap", pk(0, 4), 32'hFFFF_5346);
		wr <= 1;
		issue(8'h5A, 0, 4, 2, 0);
		check("tbl_write", pk(0, 2), 0);
		wr <= 0;
	endtask

	task automatic t_suspend();
		int n;
		prog <= 1;
		repeat (8) @(posedge clk_in);
		issue(8'h9F, 0, 0, 3, 0);
		check("ident_busy", pk(0, 3), 0);
		issue(8'h5A, 0, 4, 2, 0);
		check("tbl_busy", pk(0, 2), 0);
		issue(8'h75, 0, 0, 0, 0);
		check("sus_prog", suspended_flags_out, 2'b01);
		repeat (24) @(posedge clk_in);
		check("sus_idle", op_in_progress_flag_out, 0);
		for (int i = 0; i < 12; i++) begin
			n = n_ref;
			issue(PNO[i], 0, 0, 0, 0);
			check("prog_refuse", n_ref - n, 1);
		end
		issue(8'h7A, 0, 0, 0, 0);
		check("res_flag", suspended_flags_out, 0);
		repeat (41) @(posedge clk_in);
		check("res_busy", op_in_progress_flag_out, 1);
		prog <= 0;
		ers <= 1;
		repeat (8) @(posedge clk_in);
		issue(8'h75, 0, 0, 0, 0);
		issue(8'h75, 0, 0, 0, 0);
		check("sus_erase", suspended_flags_out, 2'b10);
		repeat (24) @(posedge clk_in);
		for (int i = 0; i < 10; i++) begin
			n = n_ref;
			issue(PNO[i], 0, 0, 0, 0);
			check("erase_refuse", n_ref - n, (i != 4));
		end
		nrst_in <= 0;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1;
		repeat (2) @(posedge clk_in);
		check("rst_flags", suspended_flags_out, 0);
		ers <= 0;
	endtask

	initial begin
		repeat (4) @(posedge clk_in);
		nrst_in <= 1;
		repeat (2) @(posedge clk_in);
		t_ident();
		t_tables();
		t_suspend();
		conclude();
	end
endmodule
